// >>> rtl/tmr2_top.sv
`timescale 1ns/1ps
`default_nettype none
module tmr2_top (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rstn,
  // apb slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [tmr2_pkg::APB_AW-1:0]  paddr,
  input  wire logic [tmr2_pkg::APB_DW-1:0]  pwdata,
  input  wire logic [3:0]                   pstrb,
  output logic                              pready,
  output logic [tmr2_pkg::APB_DW-1:0]       prdata,
  output logic                              pslverr,
  // count pin, two-way
  input  wire logic                         count_clock_pin_i,
  output logic                              count_clock_pin_o,
  output logic                              count_clock_pin_oe_n,
  // trigger pin
  input  wire logic                         ext_trigger_pin_i,
  // uart baud clocks
  output logic                              uart_rx_baud_tick,
  output logic                              uart_tx_baud_tick,
  // interrupt
  output logic                              irq
);
  import tmr2_pkg::*;

  // state registers
  logic [7:0]       ctrl_reg;
  logic [7:0]       ctrl_next;
  logic [7:0]       mode_reg;
  logic [7:0]       mode_next;
  logic [15:0]      rcap_reg;
  logic [15:0]      rcap_next;
  logic [15:0]      count_reg;
  logic [15:0]      count_next;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_stat_next;
  logic [IRQ_W-1:0] irq_en_reg;
  logic [IRQ_W-1:0] irq_en_next;
  logic             clkout_reg;
  logic             clkout_next;
  logic             pin_oe_n_reg;
  logic             rx_tick_reg;
  logic             tx_tick_reg;
  logic             irq_reg;
  logic             pready_reg;
  logic [APB_DW-1:0] prdata_reg;
  logic             pslverr_reg;

  // pin synchronisers, bit 0 count pin, bit 1 trigger pin
  wire  [1:0] pin_raw = {ext_trigger_pin_i, count_clock_pin_i};
  logic [1:0] pin_fall;

  for (genvar g = 0; g < 2; g++) begin : g_sync
    tmr2_edge_sync u_sync (
      .clk    (clk),
      .rstn   (rstn),
      .pin_in (pin_raw[g]),
      .fall   (pin_fall[g])
    );
  end

  wire count_fall = pin_fall[0];
  wire trig_fall  = pin_fall[1];

  // control fields
  wire run_control           = ctrl_reg[CTL_RUN];
  wire counter_timer_select  = ctrl_reg[CTL_CT];
  wire capture_reload_select = ctrl_reg[CTL_CPRL];
  wire ext_trigger_enable    = ctrl_reg[CTL_EXEN];
  wire uart_rx_clock_select  = ctrl_reg[CTL_RCLK];
  wire uart_tx_clock_select  = ctrl_reg[CTL_UART_TX_CLOCK_SELECT];
  wire clock_output_enable   = mode_reg[MOD_OE];

  // mode selection
  wire        baud_select = uart_rx_clock_select | uart_tx_clock_select;
  tmr2_mode_t mode;

  assign mode = baud_select           ? MODE_BAUD :
                capture_reload_select ? MODE_CAPTURE :
                clock_output_enable   ? MODE_CLKOUT :
                                        MODE_RELOAD;

  wire in_capture = (mode == MODE_CAPTURE);
  wire in_reload  = (mode == MODE_RELOAD);
  wire in_clkout  = (mode == MODE_CLKOUT);

  // count source and run gate
  wire count_src = counter_timer_select ? count_fall : 1'b1;
  wire tick      = run_control & count_src;

  // overflow and trigger events
  wire overflow   = tick & (count_reg == COUNT_MAX);
  wire trig_evt   = ext_trigger_enable & trig_fall;
  wire reload_evt = (overflow & ~in_capture)
                  | (trig_evt & in_reload);
  wire capt_evt   = trig_evt & in_capture;
  wire ovf_flag_set = overflow & (in_capture | in_reload);

  // clock-out pin drive
  wire pin_drive = clock_output_enable & ~counter_timer_select;

  // apb decode
  wire [IDX_W-1:0] idx     = paddr[APB_AW-1:2];
  wire             aligned = (paddr[1:0] == 2'b00);
  wire             access  = psel & penable;
  wire             commit  = access & pready_reg;
  wire             wr_en   = commit & pwrite & pstrb[0];
  wire [7:0]       wbyte   = pwdata[7:0];

  wire hit_ctrl     = aligned & (idx == IDX_CTRL);
  wire hit_mode     = aligned & (idx == IDX_MODE);
  wire hit_rcap_lo  = aligned & (idx == IDX_RCAP_LO);
  wire hit_rcap_hi  = aligned & (idx == IDX_RCAP_HI);
  wire hit_count_lo = aligned & (idx == IDX_COUNT_LO);
  wire hit_count_hi = aligned & (idx == IDX_COUNT_HI);
  wire hit_irq_stat = aligned & (idx == IDX_IRQ_STAT);
  wire hit_irq_clr  = aligned & (idx == IDX_IRQ_CLR);
  wire hit_irq_en   = aligned & (idx == IDX_IRQ_EN);
  wire mapped = hit_ctrl | hit_mode | hit_rcap_lo | hit_rcap_hi | hit_count_lo
              | hit_count_hi | hit_irq_stat | hit_irq_clr | hit_irq_en;

  wire wr_ctrl     = wr_en & hit_ctrl;
  wire wr_mode     = wr_en & hit_mode;
  wire wr_rcap_lo  = wr_en & hit_rcap_lo;
  wire wr_rcap_hi  = wr_en & hit_rcap_hi;
  wire wr_count_lo = wr_en & hit_count_lo;
  wire wr_count_hi = wr_en & hit_count_hi;
  wire wr_irq_clr  = wr_en & hit_irq_clr;
  wire wr_irq_en   = wr_en & hit_irq_en;

  // read data selection
  wire [7:0] rd_byte =
      hit_ctrl     ? ctrl_reg :
      hit_mode     ? (mode_reg & MOD_MASK) :
      hit_rcap_lo  ? rcap_reg[7:0] :
      hit_rcap_hi  ? rcap_reg[15:8] :
      hit_count_lo ? count_reg[7:0] :
      hit_count_hi ? count_reg[15:8] :
      hit_irq_stat ? {6'h00, irq_stat_reg} :
      hit_irq_en   ? {6'h00, irq_en_reg} :
                     8'h00;

  // counter next value, software byte write wins over counting
  always_comb begin
    count_next = count_reg;
    if (reload_evt) begin
      count_next = rcap_reg;
    end else if (tick) begin
      count_next = count_reg + COUNT_ONE;
    end
    if (wr_count_lo) begin
      count_next[7:0] = wbyte;
    end
    if (wr_count_hi) begin
      count_next[15:8] = wbyte;
    end
  end

  // capture/reload pair next value
  always_comb begin
    rcap_next = rcap_reg;
    if (capt_evt) begin
      rcap_next = count_reg;
    end
    if (wr_rcap_lo) begin
      rcap_next[7:0] = wbyte;
    end
    if (wr_rcap_hi) begin
      rcap_next[15:8] = wbyte;
    end
  end

  // control register, hardware flag set wins over software clear
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = wbyte;
    end
    if (ovf_flag_set) begin
      ctrl_next[CTL_OVF] = 1'b1;
    end
    if (trig_evt) begin
      ctrl_next[CTL_EXF] = 1'b1;
    end
  end

  // mode register keeps only the clock-output enable
  always_comb begin
    mode_next = mode_reg;
    if (wr_mode) begin
      mode_next = wbyte & MOD_MASK;
    end
  end

  // interrupt status: set wins over write-one-to-clear
  wire [IRQ_W-1:0] irq_set;
  wire [IRQ_W-1:0] irq_clr = wr_irq_clr ? wbyte[IRQ_W-1:0] : '0;

  assign irq_set[IRQ_OVF] = ovf_flag_set;
  assign irq_set[IRQ_EXT] = trig_evt;

  always_comb begin
    irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;
    irq_en_next   = wr_irq_en ? wbyte[IRQ_W-1:0] : irq_en_reg;
  end

  // clock-out toggle on each overflow while in MODE_CLKOUT
  always_comb begin
    clkout_next = clkout_reg;
    if (overflow & in_clkout) begin
      clkout_next = ~clkout_reg;
    end
  end

  // timer registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg  <= RST_CTRL;
      mode_reg  <= RST_MODE;
      rcap_reg  <= RST_RCAP;
      count_reg <= RST_COUNT;
    end else begin
      ctrl_reg  <= ctrl_next;
      mode_reg  <= mode_next;
      rcap_reg  <= rcap_next;
      count_reg <= count_next;
    end
  end

  // interrupt registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat_reg <= RST_IRQ;
      irq_en_reg   <= RST_IRQ;
      irq_reg      <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_en_reg   <= irq_en_next;
      irq_reg      <= |(irq_stat_next & irq_en_next);
    end
  end

  // pin and uart outputs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clkout_reg   <= 1'b0;
      pin_oe_n_reg <= 1'b1;
      rx_tick_reg  <= 1'b0;
      tx_tick_reg  <= 1'b0;
    end else begin
      clkout_reg   <= clkout_next;
      pin_oe_n_reg <= ~pin_drive;
      rx_tick_reg  <= overflow & uart_rx_clock_select;
      tx_tick_reg  <= overflow & uart_tx_clock_select;
    end
  end

  // apb answer: one wait state, then pready for one cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= access & ~pready_reg;
      pslverr_reg <= access & ~pready_reg & ~mapped;
      if (access & ~pready_reg & ~pwrite) begin
        prdata_reg <= {24'h000000, rd_byte};
      end else if (commit) begin
        prdata_reg <= '0;
      end
    end
  end

  // output drive
  assign pready               = pready_reg;
  assign prdata               = prdata_reg;
  assign pslverr              = pslverr_reg;
  assign count_clock_pin_o    = clkout_reg;
  assign count_clock_pin_oe_n = pin_oe_n_reg;
  assign uart_rx_baud_tick    = rx_tick_reg;
  assign uart_tx_baud_tick    = tx_tick_reg;
  assign irq                  = irq_reg;

endmodule
`default_nettype wire

// >>> rtl/tmr2_pkg.sv
package tmr2_pkg;

  // apb geometry
  localparam int APB_AW = 12;
  localparam int APB_DW = 32;
  localparam int IDX_W  = 10;

  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CTRL     = 10'h0c8;
  localparam logic [IDX_W-1:0] IDX_MODE     = 10'h0c9;
  localparam logic [IDX_W-1:0] IDX_RCAP_LO  = 10'h0ca;
  localparam logic [IDX_W-1:0] IDX_RCAP_HI  = 10'h0cb;
  localparam logic [IDX_W-1:0] IDX_COUNT_LO = 10'h0cc;
  localparam logic [IDX_W-1:0] IDX_COUNT_HI = 10'h0cd;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 10'h0d0;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLR  = 10'h0d1;
  localparam logic [IDX_W-1:0] IDX_IRQ_EN   = 10'h0d2;

  // control register fields
  localparam int CTL_OVF  = 7;
  localparam int CTL_EXF  = 6;
  localparam int CTL_RCLK = 5;
  localparam int CTL_UART_TX_CLOCK_SELECT = 4;
  localparam int CTL_EXEN = 3;
  localparam int CTL_RUN  = 2;
  localparam int CTL_CT   = 1;
  localparam int CTL_CPRL = 0;

  // mode register fields
  localparam int          MOD_OE   = 1;
  localparam logic [7:0]  MOD_MASK = 8'h02;

  // interrupt status fields
  localparam int IRQ_W   = 2;
  localparam int IRQ_OVF = 0;
  localparam int IRQ_EXT = 1;

  // reset values
  localparam logic [7:0]       RST_CTRL  = 8'h00;
  localparam logic [7:0]       RST_MODE  = 8'h00;
  localparam logic [15:0]      RST_RCAP  = 16'h0000;
  localparam logic [15:0]      RST_COUNT = 16'h0000;
  localparam logic [IRQ_W-1:0] RST_IRQ   = 2'h0;

  // counter limits
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_ONE = 16'h0001;

  // operating modes
  typedef enum logic [3:0] {
    MODE_CAPTURE = 4'b0001,
    MODE_RELOAD  = 4'b0010,
    MODE_BAUD    = 4'b0100,
    MODE_CLKOUT  = 4'b1000
  } tmr2_mode_t;

endpackage

// >>> rtl/tmr2_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none
module tmr2_edge_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // pin side
  input  wire logic pin_in,
  // synchronised side
  output logic      fall
);

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // two-flop synchroniser then one stage of history
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // falling edge: previous high, current low
  assign fall = prev_reg & ~sync_reg;

endmodule
`default_nettype wire

// >>> verif/tmr2_pins.sv
`timescale 1ns/1ps
`default_nettype none
module tmr2_pins (
  // clock
  input  wire logic clk,
  // block drive of the count pin
  input  wire logic pin_o,
  input  wire logic oe_n,
  // pin levels seen by the block
  output var logic  count_pin,
  output var logic  trig_pin
);
  logic cnt_drv = 1'b1;
  logic trg_drv = 1'b1;
  // pins idle high on pull-ups; block drive wins while enabled
  assign count_pin = oe_n ? cnt_drv : pin_o;
  assign trig_pin  = trg_drv;
  // n falling edges, each level held a random 2 to 5 cycles
  task automatic fall(input bit trg, input int n);
    repeat (n) begin
      if (trg) trg_drv <= 1'b0;
      else cnt_drv <= 1'b0;
      repeat ($urandom_range(2, 5)) @(posedge clk);
      trg_drv <= 1'b1;
      cnt_drv <= 1'b1;
      repeat ($urandom_range(2, 5)) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// >>> verif/tmr2_chk.sv
`timescale 1ns/1ps
`default_nettype none
module tmr2_chk (
  // clock and reset
  input wire logic                        clk,
  input wire logic                        rstn,
  // apb
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [tmr2_pkg::APB_AW-1:0] paddr,
  input wire logic [tmr2_pkg::APB_DW-1:0] pwdata,
  input wire logic [3:0]                  pstrb,
  input wire logic                        pready,
  input wire logic [tmr2_pkg::APB_DW-1:0] prdata,
  input wire logic                        pslverr,
  // pins and outputs
  input wire logic                        count_clock_pin_i,
  input wire logic                        count_clock_pin_o,
  input wire logic                        count_clock_pin_oe_n,
  input wire logic                        ext_trigger_pin_i,
  input wire logic                        uart_rx_baud_tick,
  input wire logic                        uart_tx_baud_tick,
  input wire logic                        irq
);
  import tmr2_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // bus answer timing and error reporting
  wait_one_a: assert property (psel && !penable |-> ##2 pready) else $error("late pready");
  rdy_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
  rdy_access_a: assert property (pready |-> psel && penable) else $error("stray pready");
  err_rdy_a: assert property (pslverr |-> pready) else $error("stray pslverr");
  unal_err_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("unaligned accepted");
  map_ok_a: assert property (pready && paddr[1:0] == 2'h0 &&
    paddr[APB_AW-1:2] inside {[IDX_CTRL:IDX_COUNT_HI]} |-> !pslverr) else $error("mapped err");
  rd_upper_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits");
  clr_rd_a: assert property (pready && !pwrite && paddr[APB_AW-1:2] == IDX_IRQ_CLR |->
    prdata == 32'h0) else $error("clear reg read");
  // pin drive and reset state
  oe_write_a: assert property ($fell(count_clock_pin_oe_n) |-> $past(pready && pwrite, 2))
    else $error("pin drive without write");
  co_drv_a: assert property ($changed(count_clock_pin_o) |-> !count_clock_pin_oe_n)
    else $error("toggle undriven");
  rst_quiet_a: assert property ($rose(rstn) |-> !irq && !pready && count_clock_pin_oe_n)
    else $error("reset state");
endmodule
bind tmr2_top tmr2_chk u_chk (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .count_clock_pin_i(count_clock_pin_i),
  .count_clock_pin_o(count_clock_pin_o), .count_clock_pin_oe_n(count_clock_pin_oe_n),
  .ext_trigger_pin_i(ext_trigger_pin_i), .uart_rx_baud_tick(uart_rx_baud_tick),
  .uart_tx_baud_tick(uart_tx_baud_tick), .irq(irq));
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tmr2_pkg::*;
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic        cpin, tpin, pin_o, oe_n, rxt, txt, irq, errv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [7:0]  rdv, p;
  logic [15:0] r, c, v;
  logic [7:0]  tc [4] = '{8'h08, 8'h09, 8'h01, 8'h19};
  int          num_errors, checks, rxn, txn, n;
  tmr2_top u_tmr2_top (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .count_clock_pin_i(cpin),
    .count_clock_pin_o(pin_o), .count_clock_pin_oe_n(oe_n), .ext_trigger_pin_i(tpin),
    .uart_rx_baud_tick(rxt), .uart_tx_baud_tick(txt), .irq(irq));
  tmr2_pins u_pins (.clk(clk), .pin_o(pin_o), .oe_n(oe_n), .count_pin(cpin), .trig_pin(tpin));
  // clock and baud tick counting
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    rxn += int'(rxt === 1'b1);
    txn += int'(txt === 1'b1);
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask
  // one apb transfer, waiting for pready under a bound
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
    int t;
    t = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++t < 50);
    if (pready !== 1'b1) num_errors++;
    rdv = prdata[7:0];
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    apb({i, 2'b00}, 1'b1, d);
  endtask
  task automatic rd(input logic [9:0] i, input logic [7:0] e, input string nm);
    apb({i, 2'b00}, 1'b0, 8'h00);
    chk(nm, rdv, e);
  endtask
  task automatic rd16(input logic [9:0] i, input logic [15:0] e, input string nm);
    rd(i, e[7:0], nm);
    rd(10'(i + 1), e[15:8], nm);
  endtask
  task automatic set16(input logic [9:0] i, input logic [15:0] d);
    wr(i, d[7:0]);
    wr(10'(i + 1), d[15:8]);
  endtask
  task automatic end_sim;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    end_sim();
  end
  // main sequence
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    void'($urandom(1451));
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 6; i++) rd(10'(IDX_CTRL + i), 8'h00, "rst_val");
    wr(IDX_MODE, 8'hfd);
    rd(IDX_MODE, 8'h00, "mode_rsv");
    rd(IDX_IRQ_CLR, 8'h00, "clr_rd");
    apb(12'h3c0, 1'b0, 8'h00);
    chk("unmapped", {errv, rdv}, 32'h100);
    apb({IDX_RCAP_LO, 2'b01}, 1'b1, 8'h55);
    rd(IDX_RCAP_LO, 8'h00, "unaligned");
    // write with the low byte strobe off must be dropped
    pstrb <= 4'he;
    wr(IDX_RCAP_LO, 8'h5a);
    pstrb <= 4'hf;
    rd(IDX_RCAP_LO, 8'h00, "strb_off");
    // timer runs on clocks, then holds when halted
    wr(IDX_CTRL, 8'h04);
    repeat (20) @(posedge clk);
    wr(IDX_CTRL, 8'h00);
    apb({IDX_COUNT_LO, 2'b00}, 1'b0, 8'h00);
    v[7:0] = rdv;
    apb({IDX_COUNT_HI, 2'b00}, 1'b0, 8'h00);
    v[15:8] = rdv;
    chk("runs", v > 16'd20 && v < 16'd40, 32'h1);
    repeat (10) @(posedge clk);
    rd16(IDX_COUNT_LO, v, "held");
    // pin-counted overflow in reload and capture modes, with interrupt
    for (int m = 0; m < 2; m++) begin
      r = 16'($urandom_range(0, 16'hfff0));
      set16(IDX_RCAP_LO, r);
      set16(IDX_COUNT_LO, 16'hfffe);
      wr(IDX_CTRL, {7'h03, m[0]});
      u_pins.fall(1'b0, 3);
      repeat (6) @(posedge clk);
      rd(IDX_CTRL, {7'h43, m[0]}, "ovf_flag");
      wr(IDX_CTRL, 8'h00);
      rd16(IDX_COUNT_LO, m ? 16'h0001 : 16'(r + 1), "ovf_cnt");
      rd(IDX_IRQ_STAT, 8'h01, "stat");
      wr(IDX_IRQ_EN, 8'h01);
      @(posedge clk);
      chk("irq_on", irq, 32'h1);
      wr(IDX_IRQ_EN, 8'h00);
      @(posedge clk);
      chk("irq_mask", irq, 32'h0);
      wr(IDX_IRQ_EN, 8'h01);
      wr(IDX_IRQ_CLR, 8'h01);
      @(posedge clk);
      chk("irq_clr", irq, 32'h0);
      rd(IDX_IRQ_STAT, 8'h00, "stat_clr");
    end
    // trigger edges while halted: reload, capture, ignored, baud
    foreach (tc[i]) begin
      c = 16'($urandom);
      r = 16'($urandom);
      set16(IDX_COUNT_LO, c);
      set16(IDX_RCAP_LO, r);
      wr(IDX_CTRL, tc[i]);
      u_pins.fall(1'b1, 1);
      repeat (6) @(posedge clk);
      rd(IDX_CTRL, tc[i] | (tc[i][3] ? 8'h40 : 8'h00), "ext_flag");
      rd(IDX_IRQ_STAT, tc[i][3] ? 8'h02 : 8'h00, "ext_stat");
      rd16(IDX_COUNT_LO, tc[i] == 8'h08 ? r : c, "trg_cnt");
      rd16(IDX_RCAP_LO, tc[i] == 8'h09 ? c : r, "trg_cap");
      wr(IDX_CTRL, 8'h00);
      wr(IDX_IRQ_CLR, 8'h03);
    end
    // baud ticks per select, no overflow flag
    for (int s = 0; s < 2; s++) begin
      set16(IDX_RCAP_LO, 16'hfff8);
      set16(IDX_COUNT_LO, 16'hfff8);
      rxn = 0;
      txn = 0;
      wr(IDX_CTRL, s ? 8'h14 : 8'h24);
      repeat (40) @(posedge clk);
      rd(IDX_CTRL, s ? 8'h14 : 8'h24, "baud_noovf");
      wr(IDX_CTRL, 8'h00);
      chk("rx_tick", rxn > 0, 32'(s == 0));
      chk("tx_tick", txn > 0, 32'(s == 1));
    end
    // clock output: half period is one reload-to-overflow span
    set16(IDX_RCAP_LO, 16'hfff0);
    wr(IDX_MODE, 8'h02);
    repeat (2) @(posedge clk);
    chk("oe_on", oe_n, 32'h0);
    wr(IDX_CTRL, 8'h04);
    repeat (2) begin
      p = {7'h0, pin_o};
      n = 0;
      do begin @(posedge clk); n++; end while (pin_o === p[0] && n < 100);
    end
    chk("half_per", n, 32'd16);
    rd(IDX_CTRL, 8'h04, "co_noovf");
    wr(IDX_CTRL, 8'h00);
    wr(IDX_MODE, 8'h00);
    repeat (2) @(posedge clk);
    chk("oe_off", oe_n, 32'h1);
    end_sim();
  end
endmodule
`default_nettype wire
